// ==== rtl/drb_map.vh ====
/*
  Register offsets, field positions and reset values of the DDR2 command block.
  Assumes it is included by bare name; it also defines the legal codes, command codes and column pipeline depth.
*/
`ifndef DRB_MAP_VH
`define DRB_MAP_VH

// Register byte offsets on the bus.
`define DRB_OFS_MAIN_CFG 8'h00
`define DRB_OFS_EXT_CFG 8'h04
`define DRB_OFS_STATUS 8'h08
`define DRB_OFS_COUNT 8'h0c

// Main configuration fields.
`define DRB_BL_LSB 0
`define DRB_BL_MSB 2
`define DRB_BT_BIT 3
`define DRB_CL_LSB 4
`define DRB_CL_MSB 6

// Extended configuration field.
`define DRB_AL_LSB 3
`define DRB_AL_MSB 5

// Legal codes and limits.
`define DRB_BL_CODE4 3'h2
`define DRB_BL_CODE8 3'h3
`define DRB_CL_MIN 3'h3
`define DRB_CL_MAX 3'h6
`define DRB_AL_MAX 3'h6

// Reset values.
`define DRB_RST_BL 3'h2
`define DRB_RST_BT 1'h0
`define DRB_RST_CL 3'h3
`define DRB_RST_AL 3'h0

// Command codes on row, column and write strobes.
`define DRB_CMD_REFRESH 3'h1
`define DRB_CMD_ACTIVATE 3'h3
`define DRB_CMD_READ 3'h5
`define DRB_CMD_WRITE 3'h4
`define DRB_CMD_PRECHARGE 3'h2
`define DRB_CMD_NOP 3'h7

// Posted column pipeline depth in link cycles.
`define DRB_PIPE_DEPTH 16

`endif

// ==== rtl/drb_burst_addr.v ====
/*
  Column address of one burst beat from the start column, beat index and mode.
  Assumes purely combinational use by the device core.
*/
`timescale 1ns/1ps
module drb_burst_addr (
  // Burst setup
  input wire [9:0] start_i,
  input wire [2:0] beat_i,
  input wire len8_i,
  input wire interleave_i,
  // Column of this beat
  output wire [9:0] col_o
);
  wire [2:0] beat_w;
  wire [1:0] low_seq_w;
  wire [2:0] low_w;

  // Only the low bits change, so a beat never leaves its aligned group.
  assign beat_w = len8_i ? beat_i : {1'b0, beat_i[1:0]};
  assign low_seq_w = start_i[1:0] + beat_w[1:0];
  assign low_w = interleave_i ? (start_i[2:0] ^ beat_w) :
    {start_i[2] ^ beat_w[2], low_seq_w};
  assign col_o = {start_i[9:3], low_w};
endmodule

// ==== rtl/drb_device.v ====
/*
  DDR2 device command core: refresh, no-operation, deselect, posted column
  commands with latency, burst ordering, read strobe preamble, and a small
  classic Wishbone slave holding the mode settings and status.
  Assumes the device clock and all memory pins come from another domain and
  are much slower than clk_i, so each half period spans several clk_i cycles.
*/
// Behaviour
// - Refresh is cs, row and column strobes low, write strobe high, bank and address ignored.
// - Refresh row comes from an internal counter, never from the address pins.
// - After a refresh all eight banks are precharged and idle.
// - Chip select low with the three strobes high is a no-operation.
// - Chip select high disables the decoder; other inputs are ignored.
// - Bursts stay inside the aligned group of four or eight columns.
// - Column commands are accepted any time and held additive latency cycles.
// - Read latency is additive plus column latency; write latency one less.
// - Only burst lengths four and eight; bit three picks the order.
// - Four beats: sequential adds modulo four, interleaved XORs the index.
// - Eight beats: sequential wraps in nibble then the other; interleaved XORs.
// - There is no burst terminate command.
// - Read data after read latency, strobe low one clock before, beats on edges.
// - Back-to-back column commands at minimum spacing give a continuous stream.
// - Column latency from main config and additive from extended config set timing.
// - Additive latency of every value zero through six is supported.
`timescale 1ns/1ps
`include "drb_map.vh"
module drb_device (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Memory command pins
  input wire dev_ck_i,
  input wire clock_enable_pin_i,
  input wire chip_select_n_i,
  input wire row_strobe_n_i,
  input wire column_strobe_n_i,
  input wire write_strobe_n_i,
  input wire [2:0] bank_select_i,
  input wire [13:0] addr_i,
  // Memory data pins
  input wire [15:0] dq_i,
  output wire [15:0] dq_o,
  output wire dq_oe_o,
  input wire data_strobe_i,
  output wire data_strobe_o,
  output wire data_strobe_oe_o
);
  localparam PW = 38;

  reg [PW-1:0] pin_s1_ff;
  reg [PW-1:0] pin_s2_ff;
  reg ck_s1_ff;
  reg ck_s2_ff;
  reg ck_s3_ff;
  wire tick_rise;
  wire tick_fall;
  wire tick_edge;
  wire s_cke;
  wire s_cs_n;
  wire [2:0] s_cmd;
  wire [2:0] s_ba;
  wire [13:0] s_addr;
  wire [15:0] s_dq;

  reg [2:0] bl_code_ff;
  reg interleave_ff;
  reg [2:0] col_lat_ff;
  reg [2:0] add_lat_ff;
  reg ack_ff;
  reg [31:0] rdat_ff;
  reg [31:0] nxt_rdat;

  reg [13:0] ref_row_ff;
  reg [7:0] bank_open_ff;
  reg [15:0] ref_cnt_ff;
  reg [15:0] col_cnt_ff;

  reg [`DRB_PIPE_DEPTH-1:0] pv_ff;
  reg [`DRB_PIPE_DEPTH-1:0] pw_ff;
  reg [10*`DRB_PIPE_DEPTH-1:0] pc_ff;
  wire [3:0] rl_w;
  wire [3:0] wl_w;
  wire [3:0] rd_idx;
  wire [3:0] wr_idx;
  wire [3:0] pre_idx;
  wire [7:0] rd_base;
  wire [7:0] wr_base;
  wire rd_go;
  wire wr_go;
  wire rd_pre;
  wire col_go;
  wire [9:0] go_col;
  wire col_cmd;

  reg act_ff;
  reg wr_ff;
  reg len8_ff;
  reg il_ff;
  reg pre_ff;
  reg [9:0] start_ff;
  reg [2:0] beat_ff;
  reg [9:0] col_ff;
  reg nxt_act;
  reg nxt_wr;
  reg nxt_len8;
  reg nxt_il;
  reg [9:0] nxt_start;
  reg [2:0] nxt_beat;
  wire [9:0] nxt_col;
  wire [2:0] last_beat;

  reg [15:0] store_ff [0:1023];
  reg [15:0] dq_ff;
  reg dq_oe_ff;
  reg dqs_ff;
  reg dqs_oe_ff;

  // Pins pass two flops; the device clock gets a third for edge finding.
  always @(posedge clk_i) begin
    pin_s1_ff <= {clock_enable_pin_i, chip_select_n_i, row_strobe_n_i, column_strobe_n_i,
      write_strobe_n_i, bank_select_i, addr_i, dq_i};
    pin_s2_ff <= pin_s1_ff;
    ck_s1_ff <= dev_ck_i;
    ck_s2_ff <= ck_s1_ff;
    ck_s3_ff <= ck_s2_ff;
  end

  assign tick_rise = ck_s2_ff & ~ck_s3_ff;
  assign tick_fall = ~ck_s2_ff & ck_s3_ff;
  assign tick_edge = tick_rise | tick_fall;
  assign s_cke = pin_s2_ff[37];
  assign s_cs_n = pin_s2_ff[36];
  assign s_cmd = pin_s2_ff[35:33];
  assign s_ba = pin_s2_ff[32:30];
  assign s_addr = pin_s2_ff[29:16];
  assign s_dq = pin_s2_ff[15:0];

  // Chip select high leaves every decode below inert.
  assign col_cmd = tick_rise & ~s_cs_n & s_cke &
    ((s_cmd == `DRB_CMD_READ) | (s_cmd == `DRB_CMD_WRITE));

  // Bank and refresh state; no-operation and deselect change nothing.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ref_row_ff <= 14'h0000;
      bank_open_ff <= 8'h00;
      ref_cnt_ff <= 16'h0000;
      col_cnt_ff <= 16'h0000;
    end else if (tick_rise && !s_cs_n && s_cke) begin
      case (s_cmd)
        `DRB_CMD_REFRESH: begin
          // Each command advances the row once; there is no repeat mode.
          ref_row_ff <= ref_row_ff + 14'h0001;
          bank_open_ff <= 8'h00;
          ref_cnt_ff <= ref_cnt_ff + 16'h0001;
        end
        `DRB_CMD_ACTIVATE: begin
          bank_open_ff[s_ba] <= 1'b1;
        end
        `DRB_CMD_PRECHARGE: begin
          if (s_addr[10]) begin
            bank_open_ff <= 8'h00;
          end else begin
            bank_open_ff[s_ba] <= 1'b0;
          end
        end
        `DRB_CMD_READ, `DRB_CMD_WRITE: begin
          col_cnt_ff <= col_cnt_ff + 16'h0001;
        end
        default: begin
        end
      endcase
    end
  end

  // Posted column pipeline, one slot per link cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pv_ff <= {`DRB_PIPE_DEPTH{1'b0}};
      pw_ff <= {`DRB_PIPE_DEPTH{1'b0}};
      pc_ff <= {10*`DRB_PIPE_DEPTH{1'b0}};
    end else if (tick_rise) begin
      pv_ff <= {pv_ff[`DRB_PIPE_DEPTH-2:0], col_cmd};
      pw_ff <= {pw_ff[`DRB_PIPE_DEPTH-2:0], s_cmd == `DRB_CMD_WRITE};
      pc_ff <= {pc_ff[10*`DRB_PIPE_DEPTH-11:0], s_addr[9:0]};
    end
  end

  assign rl_w = {1'b0, add_lat_ff} + {1'b0, col_lat_ff};
  assign wl_w = rl_w - 4'h1;
  assign rd_idx = rl_w - 4'h1;
  assign wr_idx = wl_w - 4'h1;
  assign pre_idx = rl_w - 4'h2;
  assign rd_base = {1'b0, rd_idx, 3'h0} + {3'h0, rd_idx, 1'b0};
  assign wr_base = {1'b0, wr_idx, 3'h0} + {3'h0, wr_idx, 1'b0};
  assign rd_go = tick_rise & pv_ff[rd_idx] & ~pw_ff[rd_idx];
  assign wr_go = tick_rise & pv_ff[wr_idx] & pw_ff[wr_idx];
  assign rd_pre = tick_rise & pv_ff[pre_idx] & ~pw_ff[pre_idx];
  assign col_go = rd_go | wr_go;
  assign go_col = rd_go ? pc_ff[rd_base +: 10] : pc_ff[wr_base +: 10];
  assign last_beat = len8_ff ? 3'h7 : 3'h3;

  // A new start reloads the burst even mid-burst, which gives seamless
  // streams and same-type interruption; nothing else ends a burst before its last beat.
  always @* begin
    nxt_act = act_ff;
    nxt_wr = wr_ff;
    nxt_len8 = len8_ff;
    nxt_il = il_ff;
    nxt_start = start_ff;
    nxt_beat = beat_ff;
    if (col_go) begin
      nxt_act = 1'b1;
      nxt_wr = ~rd_go;
      nxt_len8 = (bl_code_ff == `DRB_BL_CODE8);
      nxt_il = interleave_ff;
      nxt_start = go_col;
      nxt_beat = 3'h0;
    end else if (tick_edge && act_ff) begin
      if (beat_ff == last_beat) begin
        nxt_act = 1'b0;
      end else begin
        nxt_beat = beat_ff + 3'h1;
      end
    end
  end

  drb_burst_addr u_addr (
    .start_i(nxt_start),
    .beat_i(nxt_beat),
    .len8_i(nxt_len8),
    .interleave_i(nxt_il),
    .col_o(nxt_col)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      act_ff <= 1'b0;
      wr_ff <= 1'b0;
      len8_ff <= 1'b0;
      il_ff <= 1'b0;
      start_ff <= 10'h000;
      beat_ff <= 3'h0;
      col_ff <= 10'h000;
    end else begin
      act_ff <= nxt_act;
      wr_ff <= nxt_wr;
      len8_ff <= nxt_len8;
      il_ff <= nxt_il;
      start_ff <= nxt_start;
      beat_ff <= nxt_beat;
      col_ff <= nxt_col;
    end
  end

  // Write data is taken at the edge that closes each beat.
  always @(posedge clk_i) begin
    if (tick_edge && act_ff && wr_ff) begin
      store_ff[col_ff] <= s_dq;
    end
  end

  // Read drive: strobe low for one link cycle, then toggling with each beat.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pre_ff <= 1'b0;
      dq_ff <= 16'h0000;
      dq_oe_ff <= 1'b0;
      dqs_ff <= 1'b0;
      dqs_oe_ff <= 1'b0;
    end else begin
      if (rd_pre) begin
        pre_ff <= 1'b1;
      end else if (rd_go || wr_go) begin
        pre_ff <= 1'b0;
      end
      if (nxt_act && !nxt_wr) begin
        dq_ff <= store_ff[nxt_col];
        dq_oe_ff <= 1'b1;
        dqs_ff <= ~nxt_beat[0];
        dqs_oe_ff <= 1'b1;
      end else begin
        dq_oe_ff <= 1'b0;
        dqs_ff <= 1'b0;
        dqs_oe_ff <= pre_ff | rd_pre;
      end
    end
  end

  assign dq_o = dq_ff;
  assign dq_oe_o = dq_oe_ff;
  assign data_strobe_o = dqs_ff;
  assign data_strobe_oe_o = dqs_oe_ff;

  // Wishbone slave: one wait-free answer per request, released after ack.
  always @* begin
    nxt_rdat = 32'h00000000;
    case (wb_adr_i)
      `DRB_OFS_MAIN_CFG: begin
        nxt_rdat[`DRB_BL_MSB:`DRB_BL_LSB] = bl_code_ff;
        nxt_rdat[`DRB_BT_BIT] = interleave_ff;
        nxt_rdat[`DRB_CL_MSB:`DRB_CL_LSB] = col_lat_ff;
      end
      `DRB_OFS_EXT_CFG: begin
        nxt_rdat[`DRB_AL_MSB:`DRB_AL_LSB] = add_lat_ff;
      end
      `DRB_OFS_STATUS: begin
        nxt_rdat = {6'h00, pre_ff, act_ff, bank_open_ff, 2'h0, ref_row_ff};
      end
      `DRB_OFS_COUNT: begin
        nxt_rdat = {col_cnt_ff, ref_cnt_ff};
      end
      default: begin
        nxt_rdat = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
      bl_code_ff <= `DRB_RST_BL;
      interleave_ff <= `DRB_RST_BT;
      col_lat_ff <= `DRB_RST_CL;
      add_lat_ff <= `DRB_RST_AL;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      if (wb_cyc_i && wb_stb_i && !ack_ff) begin
        rdat_ff <= nxt_rdat;
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == `DRB_OFS_MAIN_CFG) begin
          // Unsupported lengths or latencies leave the old setting in place.
          if (wb_dat_i[`DRB_BL_MSB:`DRB_BL_LSB] == `DRB_BL_CODE4 ||
              wb_dat_i[`DRB_BL_MSB:`DRB_BL_LSB] == `DRB_BL_CODE8) begin
            bl_code_ff <= wb_dat_i[`DRB_BL_MSB:`DRB_BL_LSB];
          end
          interleave_ff <= wb_dat_i[`DRB_BT_BIT];
          if (wb_dat_i[`DRB_CL_MSB:`DRB_CL_LSB] >= `DRB_CL_MIN &&
              wb_dat_i[`DRB_CL_MSB:`DRB_CL_LSB] <= `DRB_CL_MAX) begin
            col_lat_ff <= wb_dat_i[`DRB_CL_MSB:`DRB_CL_LSB];
          end
        end
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == `DRB_OFS_EXT_CFG &&
            wb_dat_i[`DRB_AL_MSB:`DRB_AL_LSB] <= `DRB_AL_MAX) begin
          add_lat_ff <= wb_dat_i[`DRB_AL_MSB:`DRB_AL_LSB];
        end
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
endmodule

// ==== testbench/drb_device_properties.sv ====
/* Checker for drb_device: bus answer timing, reset state, read strobe and beats.
   Assumes it is bound to drb_device and that all its inputs belong to clk_i. */
`timescale 1ns/1ps
module drb_device_chk (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Watched ports
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [15:0] dq_o,
  input wire dq_oe_o,
  input wire data_strobe_o,
  input wire data_strobe_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  AST_ACK_IDLE: assert property (!wb_stb_i |=> !wb_ack_o)
    else $error("ack unasked");
  AST_RST_QUIET: assert property ($fell(rst_i) |-> !wb_ack_o && !dq_oe_o && !data_strobe_oe_o)
    else $error("outputs busy after reset");
  AST_PRE_LOW: assert property ($rose(data_strobe_oe_o) |-> !data_strobe_o && !dq_oe_o)
    else $error("preamble not low");
  AST_PRE_LEN: assert property ($rose(dq_oe_o) |-> data_strobe_o &&
    $past(data_strobe_oe_o, 6) && !$past(data_strobe_o, 6))
    else $error("preamble short");
  AST_BEAT_HOLD: assert property (dq_oe_o && $changed(data_strobe_o) |=>
    ($stable(data_strobe_o) && $stable(dq_o)) [*2])
    else $error("beat too short");
  AST_MIN_BEATS: assert property ($rose(dq_oe_o) |-> dq_oe_o [*8])
    else $error("burst too short");
endmodule
bind drb_device drb_device_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
  .data_strobe_o(data_strobe_o), .data_strobe_oe_o(data_strobe_oe_o));

// ==== testbench/drb_ctrl_model.sv ====
/* Controller model: free running device clock, commands, write beats, read capture.
   Assumes clk_i is the 50 MHz bench clock that also samples the device outputs. */
`timescale 1ns/1ps
module drb_ctrl_model (
  // Clock
  input wire clk_i,
  // From the device
  input wire [15:0] dq_o,
  input wire dq_oe_o,
  input wire data_strobe_o,
  input wire data_strobe_oe_o,
  // To the device: cmd is cke, cs_n, row, column and write strobes
  output reg ck_o,
  output reg [4:0] cmd_o,
  output reg [2:0] ba_o,
  output reg [13:0] adr_o,
  output reg [15:0] wd_o
);
  int rises = 0;
  int cmd_rise = 0;
  int pre_at = 0;
  int beat_at = 0;
  logic p_oe = 1'h0;
  logic p_s = 1'h0;
  logic p_soe = 1'h0;
  logic [15:0] rd_q[$];
  logic [15:0] wr_q[$];
  // The memory clock runs free, in a phase unrelated to clk_i.
  initial begin
    ck_o = 1'h0;
    cmd_o = 5'h1f;
    ba_o = 3'h0;
    adr_o = 14'h0;
    wd_o = 16'h0;
    #37.3;
    forever #80 ck_o = ~ck_o;
  end
  always @(posedge ck_o) rises <= rises + 1;
  // Pins change mid-cycle so both device edges see them settled; on release bank and address invert, command goes all high.
  task automatic issue(input logic [4:0] c, input logic [2:0] b, input logic [13:0] a);
    @(negedge ck_o);
    @(posedge clk_i);
    cmd_o <= c;
    ba_o <= b;
    adr_o <= a;
    cmd_rise = rises + 1;
    @(negedge ck_o);
    @(posedge clk_i);
    cmd_o <= 5'h1f;
    ba_o <= ~b;
    adr_o <= ~a;
  endtask
  task automatic wburst(input int wl);
    wait (rises == cmd_rise + wl);
    while (wr_q.size() > 0) begin
      repeat (2) @(posedge clk_i);
      wd_o <= wr_q.pop_front();
      @(ck_o);
    end
    repeat (2) @(posedge clk_i);
    wd_o <= ~wd_o;
  endtask
  always @(posedge clk_i) begin
    p_oe <= dq_oe_o;
    p_s <= data_strobe_o;
    p_soe <= data_strobe_oe_o;
    if (data_strobe_oe_o && !p_soe) pre_at <= rises;
    if (dq_oe_o && !p_oe) beat_at <= rises;
    if (dq_oe_o && (!p_oe || data_strobe_o !== p_s)) rd_q.push_back(dq_o);
  end
endmodule

// ==== testbench/testbench.sv ====
/* Bench for drb_device: settings over Wishbone, refresh and ignored commands, bursts.
   Assumes drb_ctrl_model on the memory pins and the bound checker. */
`timescale 1ns/1ps
`include "drb_map.vh"
module testbench;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [7:0] wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, ck, dq_oe_o, data_strobe_o, data_strobe_oe_o;
  wire [4:0] cmd;
  wire [2:0] ba;
  wire [13:0] adr;
  wire [15:0] wd, dq_o;
  int err_count = 0;
  int cmp_count = 0;
  // Device clocks left after a refresh; stands in for the refresh cycle time.
  localparam int REF_GAP_CK = 16;
  logic [15:0] mem [0:1023];
  logic [31:0] rq, st, ct;
  logic [9:0] base;
  logic [2:0] cl, al;
  logic l8, il;
  initial forever #10 clk_i = ~clk_i;
  drb_device dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_ck_i(ck), .clock_enable_pin_i(cmd[4]),
    .chip_select_n_i(cmd[3]), .row_strobe_n_i(cmd[2]), .column_strobe_n_i(cmd[1]),
    .write_strobe_n_i(cmd[0]), .bank_select_i(ba), .addr_i(adr), .dq_i(wd), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .data_strobe_i(1'h0), .data_strobe_o(data_strobe_o),
    .data_strobe_oe_o(data_strobe_oe_o));
  drb_ctrl_model m (.clk_i(clk_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .data_strobe_o(data_strobe_o),
    .data_strobe_oe_o(data_strobe_oe_o), .ck_o(ck), .cmd_o(cmd), .ba_o(ba), .adr_o(adr),
    .wd_o(wd));
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rq = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 20) chk(32'h0, 32'h1, "no bus answer");
  endtask
  task automatic cfg(input logic [2:0] bl, input logic i, input logic [2:0] c, input logic [2:0] a);
    wb(1'h1, `DRB_OFS_MAIN_CFG, {25'h0, c, i, bl});
    wb(1'h1, `DRB_OFS_EXT_CFG, {26'h0, a, 3'h0});
    wb(1'h0, `DRB_OFS_MAIN_CFG, 32'h0);
    chk(rq, {25'h0, c, i, bl}, "main cfg");
  endtask
  function automatic logic [9:0] bcol(input logic [9:0] s, input logic [2:0] i);
    logic [1:0] lo;
    lo = il ? s[1:0] ^ i[1:0] : s[1:0] + i[1:0];
    return {s[9:3], s[2] ^ (l8 & i[2]), lo};
  endfunction
  // Two reads two clocks apart: seamless for four beats, an interrupt for eight.
  task automatic rd2(input logic [9:0] s1, input logic [9:0] s2, input int rl);
    int n;
    int k;
    int c1;
    n = l8 ? 12 : 8;
    k = 0;
    m.rd_q.delete();
    m.issue({2'h2, `DRB_CMD_READ}, 3'h0, {4'h0, s1});
    c1 = m.cmd_rise;
    m.issue({2'h2, `DRB_CMD_READ}, 3'h0, {4'h0, s2});
    while (m.rd_q.size() < n && k < 600) begin
      @(posedge clk_i);
      k++;
    end
    repeat (40) @(posedge clk_i);
    chk(m.rd_q.size(), n, "beat count");
    chk(m.pre_at - c1, rl - 1, "preamble");
    chk(m.beat_at - c1, rl, "read latency");
    for (int j = 0; j < n && j < m.rd_q.size(); j++) begin
      chk(m.rd_q[j], mem[j < 4 ? bcol(s1, 3'(j)) : bcol(s2, 3'(j - 4))], "beat");
    end
  endtask
  initial begin
    void'($urandom(41));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, `DRB_OFS_MAIN_CFG, 32'h0);
    chk(rq, 32'h32, "main reset");
    wb(1'h0, 8'h10, 32'h0);
    chk(rq, 32'h0, "unmapped");
    wb(1'h1, `DRB_OFS_MAIN_CFG, 32'h4d);
    wb(1'h0, `DRB_OFS_MAIN_CFG, 32'h0);
    chk(rq, 32'h4a, "length refused");
    for (int a = 0; a < 8; a++) begin
      wb(1'h1, `DRB_OFS_EXT_CFG, 32'(a << 3));
      wb(1'h0, `DRB_OFS_EXT_CFG, 32'h0);
      chk(rq, 32'((a < 7 ? a : 6) << 3), "additive");
    end
    $display("test settings done");
    wb(1'h0, `DRB_OFS_STATUS, 32'h0);
    st = rq;
    wb(1'h0, `DRB_OFS_COUNT, 32'h0);
    ct = rq;
    m.issue({2'h2, `DRB_CMD_ACTIVATE}, 3'($urandom), 14'($urandom));
    m.issue({2'h2, `DRB_CMD_PRECHARGE}, 3'h0, 14'h0400);
    m.issue({2'h2, `DRB_CMD_REFRESH}, 3'($urandom), 14'($urandom));
    repeat (REF_GAP_CK) @(posedge ck);
    m.issue(5'h01, 3'h0, 14'h0);
    m.issue(5'h17, 3'h0, 14'h0);
    m.issue(5'h19, 3'h0, 14'h0);
    m.issue(5'h1d, 3'h0, 14'h0);
    wb(1'h0, `DRB_OFS_STATUS, 32'h0);
    chk({rq[23:16], rq[13:0]}, {8'h0, st[13:0] + 14'h1}, "refresh row");
    wb(1'h0, `DRB_OFS_COUNT, 32'h0);
    chk(rq, {ct[31:16], ct[15:0] + 16'h1}, "counts");
    $display("test refresh done");
    for (int t = 0; t < 8; t++) begin
      cl = t < 2 ? (t ? 3'h6 : 3'h3) : 3'($urandom_range(6, 3));
      al = t < 2 ? (t ? 3'h6 : 3'h0) : 3'($urandom_range(6, 0));
      base = 10'($urandom) & 10'h3f8;
      cfg(`DRB_BL_CODE8, 1'h0, cl, al);
      for (int j = 0; j < 8; j++) begin
        mem[base + 10'(j)] = 16'($urandom);
        m.wr_q.push_back(mem[base + 10'(j)]);
      end
      m.issue({2'h2, `DRB_CMD_WRITE}, 3'h0, {4'h0, base});
      m.wburst(int'(al) + int'(cl) - 1);
      l8 = 1'($urandom);
      il = 1'($urandom);
      cfg(l8 ? `DRB_BL_CODE8 : `DRB_BL_CODE4, il, cl, al);
      rd2(base | 10'($urandom_range(7, 0)), base | 10'($urandom_range(7, 0)), int'(al) + int'(cl));
    end
    $display("test bursts done");
    tally_and_finish;
  end
  initial begin
    #1000000;
    err_count++;
    $display("Error %0t: run did not finish", $time);
    tally_and_finish;
  end
endmodule
